// file: hw/plhc_pkg.sv
// package: register map, field layout and reset values of the lock/holdover bank
package plhc_pkg;

	// ------------------------------------------------------------
	// register slots and their serial word addresses
	// ------------------------------------------------------------
	localparam int PLHC_NREG = 11;
	localparam int PLHC_S_TRIP = 0;
	localparam int PLHC_S_HOLD = 1;
	localparam int PLHC_S_XTAL = 2;
	localparam int PLHC_S_WIN = 3;
	localparam int PLHC_S_DACDIV = 4;
	localparam int PLHC_S_LOCK2 = 5;
	localparam int PLHC_S_REF1 = 6;
	localparam int PLHC_S_DIV2R = 7;
	localparam int PLHC_S_CAL = 8;
	localparam int PLHC_S_FB2 = 9;
	localparam int PLHC_S_RBK = 10;
	localparam logic [4:0] PLHC_ADDRS [0:PLHC_NREG-1] = '{
		5'h0E, 5'h0F, 5'h10, 5'h18, 5'h19, 5'h1A,
		5'h1B, 5'h1C, 5'h1D, 5'h1E, 5'h1F};

	// ------------------------------------------------------------
	// reset words (address bits held as zero)
	// ------------------------------------------------------------
	localparam logic [31:0] PLHC_RST [0:PLHC_NREG-1] = '{
		32'h1200_0000, 32'h8000_8000, 32'h0000_0000, 32'h0000_00C0,
		32'h0101_0000, 32'h0C08_0000, 32'h1000_1800, 32'h0040_3000,
		32'h0780_0600, 32'h0200_0600, 32'h001F_0000};

	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int PLHC_WORD_W = 32;
	localparam int PLHC_ADDR_W = 5;
	localparam int PLHC_CNT_W = 14;
	localparam int PLHC_DAC_W = 10;
	localparam int PLHC_TRIP_W = 6;
	localparam int PLHC_R2_W = 12;
	localparam int PLHC_N2_W = 18;
	localparam int PLHC_PRESC_W = 3;
	localparam int PLHC_PRE_W = 2;
	localparam int PLHC_WIN_W = 2;
	localparam int PLHC_ERR_W = 8;
	localparam int PLHC_NREF = 3;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int PLHC_HI_TRIP_LSB = 14;
	localparam int PLHC_LO_TRIP_LSB = 6;
	localparam int PLHC_RAIL_EN_BIT = 5;
	localparam int PLHC_MANUAL_DAC_VALUE_LSB = 22;
	localparam int PLHC_MAN_EN_BIT = 20;
	localparam int PLHC_HOLD_CNT_LSB = 6;
	localparam int PLHC_FORCE_BIT = 5;
	localparam int PLHC_WIN_LSB = 6;
	localparam int PLHC_DACDIV_LSB = 22;
	localparam int PLHC_LOCK1_CNT_LSB = 6;
	localparam int PLHC_LOCK2_CNT_LSB = 6;
	localparam int PLHC_PRE_LSB = 20;
	localparam int PLHC_REF1_LSB = 6;
	localparam int PLHC_REF2_LSB = 20;
	localparam int PLHC_FB1_LSB = 6;
	localparam int PLHC_FAST_BIT = 23;
	localparam int PLHC_CAL_LSB = 5;
	localparam int PLHC_PRESC_LSB = 24;
	localparam int PLHC_FB2_LSB = 5;
	localparam int PLHC_RB_LE_BIT = 21;
	localparam int PLHC_RB_ADDR_LSB = 16;
	localparam int PLHC_WLOCK_BIT = 5;

	// ------------------------------------------------------------
	// lock window table (ns) and dac trip scaling
	// ------------------------------------------------------------
	localparam logic [7:0] PLHC_WIN_NS [0:3] = '{8'h05, 8'h0A, 8'h14, 8'h28};
	localparam logic [9:0] PLHC_DAC_MAX = 10'h3FF;

	// ------------------------------------------------------------
	// holdover states
	// ------------------------------------------------------------
	typedef enum logic [0:0] {
		PLHC_ST_TRACK = 1'b0,
		PLHC_ST_HOLD = 1'b1
	} plhc_state_t;

endpackage

// file: hw/plhc_tick_div.sv
// module: divides a stream of one-cycle tick pulses by a programmable value
`timescale 1ns/1ps
module plhc_tick_div #(
	parameter int W = 14
) (
	// clock and reset
	input logic clk,
	input logic srst,
	// tick stream
	input logic tick_in,
	input logic [W-1:0] divisor,
	output logic tick_out
);
	import plhc_pkg::*;

	logic [W-1:0] cnt_q;
	logic tick_out_q;
	wire last;

	// zero divisor behaves as divide-by-1 so the stream never stalls
	assign last = (divisor <= W'(1)) || (cnt_q >= divisor - W'(1));
	assign tick_out = tick_out_q;

	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_q <= '0;
			tick_out_q <= 1'b0;
		end else begin
			tick_out_q <= tick_in & last;
			if (tick_in) begin
				cnt_q <= last ? '0 : cnt_q + W'(1);
			end
		end
	end

endmodule

// file: hw/plhc_lock_cnt.sv
// module: consecutive in-window comparison counter with lock flag
`timescale 1ns/1ps
module plhc_lock_cnt #(
	parameter int W = 14
) (
	// clock and reset
	input logic clk,
	input logic srst,
	// control
	input logic clear,
	input logic tick,
	input logic in_window,
	input logic [W-1:0] target,
	// status
	output logic locked
);
	import plhc_pkg::*;

	logic [W-1:0] cnt_q;
	logic locked_q;
	wire [W-1:0] cnt_nxt;

	// saturate so a long lock never wraps into a false unlock
	assign cnt_nxt = (&cnt_q) ? cnt_q : cnt_q + W'(1);
	assign locked = locked_q;

	always_ff @(posedge clk) begin
		if (srst || clear) begin
			cnt_q <= '0;
			locked_q <= 1'b0;
		end else if (tick && !in_window) begin
			cnt_q <= '0;
			locked_q <= 1'b0;
		end else if (tick) begin
			cnt_q <= cnt_nxt;
			locked_q <= locked_q | (cnt_nxt >= target);
		end
	end

endmodule

// file: hw/plhc_bank.sv
// module: lock detect, holdover, dac and divider register bank on serial link
//
// Operation
// RULE_01 - holdover exits after held lock count
// RULE_02 - first loop lock after programmed count
// RULE_03 - second loop lock after in-window count
// RULE_04 - first loop window from 2-bit code
// RULE_05 - manual dac value drives dac; reads dac
// RULE_06 - manual value applied only when enabled
// RULE_07 - dac update rate is pd rate divided
// RULE_08 - rail trip forces first loop unlocked
// RULE_09 - high and low 6-bit trip thresholds
// RULE_10 - force bit holds device in holdover
// RULE_11 - first loop reference divide 1 to 16383
// RULE_12 - first loop feedback divide 1 to 16383
// RULE_13 - second loop reference divide 1 to 4095
// RULE_14 - second loop prescale then feedback divide
// RULE_15 - host writes calibration equal to feedback
// RULE_16 - each reference pre-divided by 1/2/4/8
// RULE_17 - fast rate bit gates above 100 MHz
// RULE_18 - readback returns register at readback address
// RULE_19 - readback runs at selected latch level
// RULE_20 - write lock blocks writes below 31
// RULE_21 - lock falling edge enters holdover unless disabled
// RULE_22 - out-of-window comparison restarts lock counters
`timescale 1ns/1ps
module plhc_bank (
	// clock and reset
	input logic clk,
	input logic srst,
	// serial programming link
	input logic ser_clk,
	input logic ser_data,
	input logic latch_enable_pin,
	output logic readback_data,
	// first loop phase detector
	input logic pd1_cmp_tick,
	input logic [plhc_pkg::PLHC_ERR_W-1:0] pd1_phase_err_ns,
	// second loop phase detector
	input logic pd2_cmp_tick,
	input logic pd2_in_window,
	input logic pd2_rate_above_100m,
	// reference and feedback ticks
	input logic [plhc_pkg::PLHC_NREF-1:0] ref_tick,
	input logic [1:0] ref_select,
	input logic fb1_tick,
	input logic osc_tick,
	input logic vco_tick,
	// tracking and mode
	input logic [plhc_pkg::PLHC_DAC_W-1:0] dac_track_code,
	input logic lock_loss_holdover_disable,
	// status
	output logic first_loop_locked,
	output logic second_loop_locked,
	output logic holdover_active,
	output logic second_loop_rate_ok,
	// dac
	output logic [plhc_pkg::PLHC_DAC_W-1:0] dac_code,
	output logic dac_update,
	// divided ticks and calibration word
	output logic [plhc_pkg::PLHC_NREF-1:0] pre_tick,
	output logic pd1_ref_tick,
	output logic pd1_fb_tick,
	output logic pd2_ref_tick,
	output logic pd2_fb_tick,
	output logic [plhc_pkg::PLHC_N2_W-1:0] second_loop_fb_calibration
);
	import plhc_pkg::*;

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic [PLHC_WORD_W-1:0] reg_q [0:PLHC_NREG-1];
	logic [PLHC_WORD_W-1:0] sh_q;
	logic [PLHC_WORD_W-1:0] rb_q;
	logic ser_clk_q;
	logic le_q;
	logic [PLHC_DAC_W-1:0] dac_q;
	logic lock1_prev_q;
	logic rate_ok_q;
	plhc_state_t st_q;
	plhc_state_t st_d;
	wire [PLHC_NREG-1:0] hit;
	wire sclk_rise;
	wire sclk_fall;
	wire commit;
	wire wlock;
	wire rb_level;
	wire at_rb_level;
	wire rb_enter;
	wire [PLHC_ADDR_W-1:0] rb_addr;
	logic [PLHC_WORD_W-1:0] rd_word;
	wire [PLHC_TRIP_W-1:0] hi_trip;
	wire [PLHC_TRIP_W-1:0] lo_trip;
	wire rail_en;
	wire rail_trip;
	wire [PLHC_DAC_W-1:0] man_val;
	wire man_en;
	wire force_hold;
	wire [PLHC_CNT_W-1:0] hold_cnt;
	wire [PLHC_WIN_W-1:0] win_code;
	wire in_window1;
	wire [PLHC_DAC_W-1:0] dac_div;
	wire [PLHC_CNT_W-1:0] lock1_cnt;
	wire [PLHC_CNT_W-1:0] lock2_cnt;
	wire [PLHC_CNT_W-1:0] ref1_div;
	wire [PLHC_CNT_W-1:0] fb1_div;
	wire [PLHC_R2_W-1:0] ref2_div;
	wire [PLHC_N2_W-1:0] fb2_div;
	wire [PLHC_PRESC_W-1:0] presc;
	wire [PLHC_PRESC_W:0] presc_div;
	wire fast_rate;
	wire sel_ref;
	wire presc_tick;
	wire exit_ok;
	wire lock_fall;

	// ------------------------------------------------------------
	// field extraction
	// ------------------------------------------------------------
	assign hi_trip = reg_q[PLHC_S_TRIP][PLHC_HI_TRIP_LSB +: PLHC_TRIP_W];
	assign lo_trip = reg_q[PLHC_S_TRIP][PLHC_LO_TRIP_LSB +: PLHC_TRIP_W];
	assign rail_en = reg_q[PLHC_S_TRIP][PLHC_RAIL_EN_BIT];
	assign man_val = reg_q[PLHC_S_HOLD][PLHC_MANUAL_DAC_VALUE_LSB +: PLHC_DAC_W];
	assign man_en = reg_q[PLHC_S_HOLD][PLHC_MAN_EN_BIT];
	assign hold_cnt = reg_q[PLHC_S_HOLD][PLHC_HOLD_CNT_LSB +: PLHC_CNT_W];
	assign force_hold = reg_q[PLHC_S_HOLD][PLHC_FORCE_BIT];
	assign win_code = reg_q[PLHC_S_WIN][PLHC_WIN_LSB +: PLHC_WIN_W];
	assign dac_div = reg_q[PLHC_S_DACDIV][PLHC_DACDIV_LSB +: PLHC_DAC_W];
	assign lock1_cnt = reg_q[PLHC_S_DACDIV][PLHC_LOCK1_CNT_LSB +: PLHC_CNT_W];
	assign lock2_cnt = reg_q[PLHC_S_LOCK2][PLHC_LOCK2_CNT_LSB +: PLHC_CNT_W];
	assign ref1_div = reg_q[PLHC_S_REF1][PLHC_REF1_LSB +: PLHC_CNT_W];
	assign ref2_div = reg_q[PLHC_S_DIV2R][PLHC_REF2_LSB +: PLHC_R2_W];
	assign fb1_div = reg_q[PLHC_S_DIV2R][PLHC_FB1_LSB +: PLHC_CNT_W];
	assign fast_rate = reg_q[PLHC_S_CAL][PLHC_FAST_BIT];
	assign second_loop_fb_calibration =
		reg_q[PLHC_S_CAL][PLHC_CAL_LSB +: PLHC_N2_W];
	assign presc = reg_q[PLHC_S_FB2][PLHC_PRESC_LSB +: PLHC_PRESC_W];
	assign fb2_div = reg_q[PLHC_S_FB2][PLHC_FB2_LSB +: PLHC_N2_W];
	assign rb_level = reg_q[PLHC_S_RBK][PLHC_RB_LE_BIT];
	assign rb_addr = reg_q[PLHC_S_RBK][PLHC_RB_ADDR_LSB +: PLHC_ADDR_W];
	assign wlock = reg_q[PLHC_S_RBK][PLHC_WLOCK_BIT];

	// ------------------------------------------------------------
	// serial link: shift in, latch, readback
	// ------------------------------------------------------------
	assign sclk_rise = ser_clk & ~ser_clk_q;
	assign sclk_fall = ~ser_clk & ser_clk_q;
	assign commit = latch_enable_pin & ~le_q;
	assign at_rb_level = (latch_enable_pin == rb_level); // RULE_19
	assign rb_enter = at_rb_level && (le_q != rb_level); // RULE_19
	assign readback_data = rb_q[PLHC_WORD_W-1];

	always_ff @(posedge clk) begin
		if (srst) begin
			ser_clk_q <= 1'b0;
			le_q <= 1'b0;
			sh_q <= '0;
		end else begin
			ser_clk_q <= ser_clk;
			le_q <= latch_enable_pin;
			if (sclk_rise) begin
				sh_q <= {sh_q[PLHC_WORD_W-2:0], ser_data};
			end
		end
	end

	// word loaded on entry to the readback level, shifted msb first
	always_ff @(posedge clk) begin
		if (srst) begin
			rb_q <= '0;
		end else if (rb_enter) begin
			rb_q <= rd_word; // RULE_18
		end else if (sclk_fall && at_rb_level) begin
			rb_q <= {rb_q[PLHC_WORD_W-2:0], 1'b0}; // RULE_19
		end
	end

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	for (genvar i = 0; i < PLHC_NREG; i++) begin : g_reg
		// lock bit covers every register but the readback one
		assign hit[i] = commit && (sh_q[PLHC_ADDR_W-1:0] == PLHC_ADDRS[i])
			&& (!wlock || (i == PLHC_S_RBK)); // RULE_20
		always_ff @(posedge clk) begin
			if (srst) begin
				reg_q[i] <= PLHC_RST[i];
			end else if (hit[i]) begin
				reg_q[i] <= {sh_q[PLHC_WORD_W-1:PLHC_ADDR_W], 5'h00};
			end
		end
	end

	// unmapped addresses read as zero; dac field shows live dac
	function automatic logic [PLHC_WORD_W-1:0] read_word(
		input logic [PLHC_ADDR_W-1:0] a);
		logic [PLHC_WORD_W-1:0] w;
		w = '0;
		for (int k = 0; k < PLHC_NREG; k++) begin
			if (a == PLHC_ADDRS[k]) begin
				w = reg_q[k] | {27'h0000000, a};
			end
		end
		if (a == PLHC_ADDRS[PLHC_S_HOLD]) begin
			w[PLHC_MANUAL_DAC_VALUE_LSB +: PLHC_DAC_W] = dac_q; // RULE_05
		end
		return w;
	endfunction

	// a process, so register and dac changes re-evaluate the word
	always_comb begin
		rd_word = read_word(rb_addr); // RULE_18
	end

	// ------------------------------------------------------------
	// dividers
	// ------------------------------------------------------------
	for (genvar j = 0; j < PLHC_NREF; j++) begin : g_pre
		plhc_tick_div #(.W(4)) u_pre (
			.clk(clk),
			.srst(srst),
			.tick_in(ref_tick[j]),
			.divisor(4'h1 << reg_q[PLHC_S_REF1][PLHC_PRE_LSB + 2*j +:
				PLHC_PRE_W]), // RULE_16
			.tick_out(pre_tick[j])
		);
	end

	assign sel_ref = (ref_select == 2'h1) ? pre_tick[1] :
		(ref_select == 2'h2) ? pre_tick[2] : pre_tick[0];

	plhc_tick_div #(.W(PLHC_CNT_W)) u_ref1 (
		.clk(clk),
		.srst(srst),
		.tick_in(sel_ref),
		.divisor(ref1_div), // RULE_11
		.tick_out(pd1_ref_tick)
	);

	plhc_tick_div #(.W(PLHC_CNT_W)) u_fb1 (
		.clk(clk),
		.srst(srst),
		.tick_in(fb1_tick),
		.divisor(fb1_div), // RULE_12
		.tick_out(pd1_fb_tick)
	);

	plhc_tick_div #(.W(PLHC_R2_W)) u_ref2 (
		.clk(clk),
		.srst(srst),
		.tick_in(osc_tick),
		.divisor(ref2_div), // RULE_13
		.tick_out(pd2_ref_tick)
	);

	// code 0 selects divide-by-8, the top of the range
	assign presc_div = (presc == '0) ? 4'h8 : {1'b0, presc}; // RULE_14

	plhc_tick_div #(.W(PLHC_PRESC_W + 1)) u_presc (
		.clk(clk),
		.srst(srst),
		.tick_in(vco_tick),
		.divisor(presc_div), // RULE_14
		.tick_out(presc_tick)
	);

	plhc_tick_div #(.W(PLHC_N2_W)) u_fb2 (
		.clk(clk),
		.srst(srst),
		.tick_in(presc_tick),
		.divisor(fb2_div), // RULE_14
		.tick_out(pd2_fb_tick)
	);

	plhc_tick_div #(.W(PLHC_DAC_W)) u_dacclk (
		.clk(clk),
		.srst(srst),
		.tick_in(pd1_cmp_tick),
		.divisor(dac_div), // RULE_07
		.tick_out(dac_update)
	);

	// ------------------------------------------------------------
	// dac and rail detect
	// ------------------------------------------------------------
	// trip codes scale by 16 so the 6-bit field spans the full dac range
	assign rail_trip = rail_en && // RULE_08
		((dac_q >= (PLHC_DAC_MAX - {hi_trip, 4'h0})) ||
		(dac_q <= {lo_trip, 4'h0})); // RULE_09
	assign dac_code = dac_q;

	// dac freezes in holdover unless the manual override owns it
	always_ff @(posedge clk) begin
		if (srst) begin
			dac_q <= PLHC_RST[PLHC_S_HOLD][PLHC_MANUAL_DAC_VALUE_LSB +: PLHC_DAC_W];
		end else if (dac_update) begin
			if (man_en) begin
				dac_q <= man_val; // RULE_06
			end else if (st_q == PLHC_ST_TRACK) begin
				dac_q <= dac_track_code;
			end
		end
	end

	// ------------------------------------------------------------
	// lock detection
	// ------------------------------------------------------------
	assign in_window1 = pd1_phase_err_ns < PLHC_WIN_NS[win_code]; // RULE_04

	plhc_lock_cnt #(.W(PLHC_CNT_W)) u_lock1 (
		.clk(clk),
		.srst(srst),
		.clear(rail_trip), // RULE_08
		.tick(pd1_cmp_tick),
		.in_window(in_window1), // RULE_22
		.target(lock1_cnt), // RULE_02
		.locked(first_loop_locked)
	);

	plhc_lock_cnt #(.W(PLHC_CNT_W)) u_lock2 (
		.clk(clk),
		.srst(srst),
		.clear(1'b0),
		.tick(pd2_cmp_tick),
		.in_window(pd2_in_window), // RULE_22
		.target(lock2_cnt), // RULE_03
		.locked(second_loop_locked)
	);

	// counts only while holding, so each stay starts fresh
	plhc_lock_cnt #(.W(PLHC_CNT_W)) u_exit (
		.clk(clk),
		.srst(srst),
		.clear((st_q != PLHC_ST_HOLD) || rail_trip),
		.tick(pd1_cmp_tick),
		.in_window(in_window1 && !rail_trip),
		.target(hold_cnt), // RULE_01
		.locked(exit_ok)
	);

	// ------------------------------------------------------------
	// holdover control
	// ------------------------------------------------------------
	assign lock_fall = lock1_prev_q & ~first_loop_locked;
	assign holdover_active = (st_q == PLHC_ST_HOLD);
	assign second_loop_rate_ok = rate_ok_q;

	always_comb begin
		st_d = st_q;
		case (st_q)
			PLHC_ST_TRACK: begin
				if (force_hold || rail_trip || // RULE_10
					(lock_fall && !lock_loss_holdover_disable)) begin // RULE_21
					st_d = PLHC_ST_HOLD;
				end
			end
			PLHC_ST_HOLD: begin
				if (!force_hold && !rail_trip && exit_ok) begin // RULE_01
					st_d = PLHC_ST_TRACK;
				end
			end
			default: begin
				st_d = PLHC_ST_TRACK;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			st_q <= PLHC_ST_TRACK;
			lock1_prev_q <= 1'b0;
			rate_ok_q <= 1'b0;
		end else begin
			st_q <= st_d;
			lock1_prev_q <= first_loop_locked;
			rate_ok_q <= fast_rate || !pd2_rate_above_100m; // RULE_17
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	property p_force_hold; // RULE_10
		@(posedge clk) disable iff (srst)
		force_hold |=> holdover_active;
	endproperty
	a_force_hold: assert property (p_force_hold) // RULE_10
		else $error("force bit did not hold the device in holdover");

	property p_fall_hold; // RULE_21
		@(posedge clk) disable iff (srst)
		lock_fall && !lock_loss_holdover_disable |=> holdover_active;
	endproperty
	a_fall_hold: assert property (p_fall_hold) // RULE_21
		else $error("lock loss did not enter holdover");

	property p_exit_gate; // RULE_01
		@(posedge clk) disable iff (srst)
		$fell(holdover_active) |-> $past(exit_ok) && !$past(force_hold);
	endproperty
	a_exit_gate: assert property (p_exit_gate) // RULE_01
		else $error("holdover left before lock count met");

	property p_wlock; // RULE_20
		@(posedge clk) disable iff (srst)
		commit && wlock && sh_q[PLHC_ADDR_W-1:0] == PLHC_ADDRS[PLHC_S_REF1]
		|=> $stable(reg_q[PLHC_S_REF1]);
	endproperty
	a_wlock: assert property (p_wlock) // RULE_20
		else $error("locked register accepted a write");

	property p_manual_dac_value; // RULE_06
		@(posedge clk) disable iff (srst)
		dac_update && man_en |=> dac_code == $past(man_val);
	endproperty
	a_manual_dac_value: assert property (p_manual_dac_value) // RULE_06
		else $error("manual dac value not applied");

	property p_rail_unlock; // RULE_08
		@(posedge clk) disable iff (srst)
		rail_trip |=> !first_loop_locked ##1 holdover_active;
	endproperty
	a_rail_unlock: assert property (p_rail_unlock) // RULE_08
		else $error("rail trip did not unlock the first loop");

	property p_window_restart; // RULE_22
		@(posedge clk) disable iff (srst)
		pd1_cmp_tick && !in_window1 |=> !first_loop_locked;
	endproperty
	a_window_restart: assert property (p_window_restart) // RULE_22
		else $error("out-of-window comparison kept lock");

	property p_readback; // RULE_18
		@(posedge clk) disable iff (srst)
		rb_enter |=> readback_data == $past(rd_word[PLHC_WORD_W-1]);
	endproperty
	a_readback: assert property (p_readback) // RULE_18
		else $error("readback word not loaded from selected register");

	property p_fast_rate; // RULE_17
		@(posedge clk) disable iff (srst)
		pd2_rate_above_100m && !fast_rate |=> !second_loop_rate_ok;
	endproperty
	a_fast_rate: assert property (p_fast_rate) // RULE_17
		else $error("fast rate accepted with fast bit clear");

endmodule

// file: verification/plhc_host.sv
// host model on the three-wire serial programming link
`timescale 1ns/1ps
module plhc_host (
	// clock
	input wire logic clk,
	// serial link
	output logic ser_clk,
	output logic ser_data,
	output logic latch_enable_pin,
	input wire logic readback_data
);
	// --------
	// link driver
	// --------
	logic busy = 1'b0;
	initial begin
		ser_clk = 1'b0;
		ser_data = 1'b0;
		latch_enable_pin = 1'b0;
	end
	// released data line toggles so a stale bit never passes for data
	always @(negedge clk)
		if (!busy)
			ser_data <= !ser_data;
	// data in [31:5], address in [4:0], msb first
	task automatic wr(input logic [31:0] w);
		busy = 1'b1;
		@(negedge clk);
		for (int i = 31; i >= 0; i--) begin
			ser_data = w[i];
			ser_clk = 1'b0;
			@(negedge clk);
			ser_clk = 1'b1;
			@(negedge clk);
		end
		ser_clk = 1'b0;
		latch_enable_pin = 1'b1;
		// long latch pulse: commit lands before the readback load
		repeat (3) @(negedge clk);
		latch_enable_pin = 1'b0;
		@(negedge clk);
		busy = 1'b0;
	endtask
	// readback level kept low, so the latch stays low while shifting
	task automatic rd(input logic [4:0] a, input logic lk,
			output logic [31:0] v);
		wr({11'h0, a, 10'h0, lk, 5'h1F});
		busy = 1'b1;
		repeat (2) @(negedge clk);
		v[31] = readback_data;
		for (int i = 30; i >= 0; i--) begin
			ser_clk = 1'b1;
			@(negedge clk);
			ser_clk = 1'b0;
			repeat (2) @(negedge clk);
			v[i] = readback_data;
		end
		busy = 1'b0;
	endtask
endmodule

// file: verification/plhc_bank_test.sv
// testbench: register, divider, lock and holdover checks of the bank
`timescale 1ns/1ps
module plhc_bank_test;
	import plhc_pkg::*;
	// --------
	// signals and helpers
	// --------
	logic clk = 1'b0;
	logic srst;
	logic ser_clk, ser_data, latch_enable_pin, readback_data;
	logic pd1_cmp_tick, pd2_cmp_tick, pd2_in_window, pd2_rate_above_100m;
	logic [7:0] pd1_phase_err_ns;
	logic rt, fb1_tick, osc_tick, vco_tick, lock_loss_holdover_disable;
	logic [5:0] tk;
	logic [5:0] rz = 6'h00;
	logic [1:0] ref_select;
	logic [2:0] ref_tick, pre_tick;
	logic [9:0] dac_track_code, dac_code;
	logic first_loop_locked, second_loop_locked, holdover_active;
	logic second_loop_rate_ok, dac_update, pd1_ref_tick, pd1_fb_tick;
	logic pd2_ref_tick, pd2_fb_tick;
	logic [17:0] second_loop_fb_calibration;
	logic [31:0] v, w1b;
	int err_count = 0;
	int n_compared = 0;
	int seed = 32'h5eb10cf7;
	int npd1 = 0;
	int d, mv;
	int c[6];
	assign ref_tick = 3'(rt) << ref_select;
	assign {pd1_cmp_tick, pd2_cmp_tick, rt, fb1_tick, osc_tick, vco_tick} = tk;
	always #4 clk = !clk;
	always @(posedge clk) begin
		c[0] += int'(pd1_ref_tick);
		c[1] += int'(pd1_fb_tick);
		c[2] += int'(pd2_ref_tick);
		c[3] += int'(pd2_fb_tick);
		c[4] += int'(dac_update);
		c[5] += int'(pre_tick[ref_select]);
	end
	plhc_bank plhc_bank_i (.clk, .srst, .ser_clk, .ser_data,
		.latch_enable_pin, .readback_data, .pd1_cmp_tick,
		.pd1_phase_err_ns, .pd2_cmp_tick, .pd2_in_window,
		.pd2_rate_above_100m, .ref_tick, .ref_select, .fb1_tick,
		.osc_tick, .vco_tick, .dac_track_code,
		.lock_loss_holdover_disable, .first_loop_locked,
		.second_loop_locked, .holdover_active, .second_loop_rate_ok,
		.dac_code, .dac_update, .pre_tick, .pd1_ref_tick, .pd1_fb_tick,
		.pd2_ref_tick, .pd2_fb_tick, .second_loop_fb_calibration);
	plhc_host plhc_host_i (.clk, .ser_clk, .ser_data, .latch_enable_pin,
		.readback_data);
	function automatic int rnd(input int m);
		return int'($unsigned($random(seed)) % m);
	endfunction
	function automatic int quo(input int n, input int dv);
		return n / dv;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic complete_run();
		if (err_count == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic rst();
		srst = 1'b1;
		repeat (3) @(negedge clk);
		srst = 1'b0;
		@(negedge clk);
	endtask
	// n one-cycle pulses on the inputs chosen by m, err for both loops
	task automatic pulse(input int n, input logic [5:0] m,
			input logic [7:0] e);
		for (int i = 0; i < n; i++) begin
			tk = m | (6'($random(seed)) & rz);
			pd1_phase_err_ns = e;
			pd2_in_window = e < 8'h28;
			@(negedge clk);
			tk = 6'h00;
			// comparison fields only count with a tick
			pd1_phase_err_ns = 8'($random(seed));
			pd2_in_window = rnd(2) != 0;
			@(negedge clk);
		end
		if (m[5])
			npd1 += n;
		repeat (2) @(negedge clk);
	endtask
	// --------
	// main sequence
	// --------
	initial begin
		tk = 6'h00;
		pd1_phase_err_ns = 8'h00;
		pd2_in_window = 1'b0;
		pd2_rate_above_100m = 1'b1;
		ref_select = 2'h0;
		dac_track_code = 10'h000;
		lock_loss_holdover_disable = 1'b0;
		rst();
		chk(dac_code, 32'h200);
		chk(second_loop_rate_ok, 32'h1);
		for (int s = 0; s < PLHC_NREG; s++) begin
			plhc_host_i.rd(PLHC_ADDRS[s], 1'b0, v);
			chk(v, PLHC_RST[s] | 32'(PLHC_ADDRS[s]));
		end
		plhc_host_i.rd(5'h03, 1'b0, v);
		chk(v, 32'h0);
		for (int k = 0; k < 3; k++) begin
			int pc, r1, n1, r2, n2, p, fs;
			pc = rnd(4);
			r1 = rnd(6) + 1;
			n1 = rnd(6) + 1;
			r2 = rnd(6) + 1;
			n2 = rnd(6) + 1;
			p = rnd(7) + 2;
			fs = rnd(2);
			rst();
			ref_select = 2'(rnd(3));
			// lock side is unchecked here, so its inputs run free
			rz = 6'h30;
			lock_loss_holdover_disable = rnd(2) != 0;
			pd2_rate_above_100m = rnd(2) != 0;
			w1b = 32'(pc << (20 + 2 * ref_select)) | 32'(r1 << 6) | 32'h1B;
			plhc_host_i.wr(w1b);
			plhc_host_i.wr(32'(r2 << 20) | 32'(n1 << 6) | 32'h1C);
			plhc_host_i.wr(32'((p % 8) << 24) | 32'(n2 << 5) | 32'h1E);
			plhc_host_i.wr(32'(fs << 23) | 32'(n2 << 5) | 32'h1D);
			plhc_host_i.rd(5'h1E, 1'b0, v);
			chk(v, 32'((p % 8) << 24) | 32'(n2 << 5) | 32'h1E);
			chk(second_loop_fb_calibration, 32'(n2));
			chk(second_loop_rate_ok, fs[0] | !pd2_rate_above_100m);
			c = '{default: 0};
			pulse(96, 6'h0F, 8'h00);
			chk(c[5], 96 >> pc);
			chk(c[0], quo(96 >> pc, r1));
			chk(c[1], quo(96, n1));
			chk(c[2], quo(96, r2));
			chk(c[3], quo(96, p * n2));
		end
		rz = 6'h00;
		lock_loss_holdover_disable = 1'b0;
		plhc_host_i.wr(32'h0000_003F);
		plhc_host_i.wr(32'hFFFF_FFDB);
		plhc_host_i.rd(5'h1B, 1'b1, v);
		chk(v, w1b);
		plhc_host_i.wr(32'h0000_001F);
		rst();
		dac_track_code = 10'(rnd(1024));
		d = rnd(4) + 2;
		c = '{default: 0};
		npd1 = 0;
		plhc_host_i.wr(32'(d << 22) | 32'h0000_0159);
		plhc_host_i.wr(32'h0000_011A);
		plhc_host_i.wr(32'h0000_00EF);
		chk(holdover_active, 32'h1);
		pulse(3, 6'h10, 8'h00);
		chk(second_loop_locked, 32'h0);
		pulse(1, 6'h10, 8'h00);
		chk(second_loop_locked, 32'h1);
		plhc_host_i.wr(32'h0000_00CF);
		pulse(2, 6'h20, 8'h1E);
		chk(holdover_active, 32'h1);
		pulse(1, 6'h20, 8'h1E);
		chk(holdover_active, 32'h0);
		pulse(1, 6'h20, 8'hC8);
		pulse(3, 6'h20, 8'h1E);
		pulse(1, 6'h20, 8'hC8);
		pulse(4, 6'h20, 8'h1E);
		chk(first_loop_locked, 32'h0);
		pulse(1, 6'h20, 8'h1E);
		chk(first_loop_locked, 32'h1);
		chk(dac_code, 32'(dac_track_code));
		lock_loss_holdover_disable = 1'b1;
		pulse(1, 6'h20, 8'hC8);
		chk(holdover_active, 32'h0);
		pulse(5, 6'h20, 8'h1E);
		lock_loss_holdover_disable = 1'b0;
		pulse(1, 6'h20, 8'hC8);
		chk(holdover_active, 32'h1);
		chk(c[4], quo(npd1, d));
		mv = rnd(1024);
		plhc_host_i.wr(32'(mv << 22) | 32'h0010_00CF);
		pulse(d, 6'h20, 8'h1E);
		chk(dac_code, 32'(mv));
		plhc_host_i.rd(5'h0F, 1'b0, v);
		chk(v[31:22], 32'(mv));
		plhc_host_i.wr(32'h0000_0018);
		pulse(6, 6'h20, 8'h0A);
		chk(first_loop_locked, 32'h0);
		pulse(5, 6'h20, 8'h04);
		chk(first_loop_locked, 32'h1);
		plhc_host_i.wr(32'h0000_00D8);
		// one below the high trip point first, then exactly on it
		plhc_host_i.wr(32'hEF90_00CF);
		pulse(d, 6'h20, 8'h1E);
		plhc_host_i.wr(32'h0001_002E);
		pulse(5, 6'h20, 8'h1E);
		chk(first_loop_locked, 32'h1);
		plhc_host_i.wr(32'hEFD0_00CF);
		pulse(d, 6'h20, 8'h1E);
		chk(first_loop_locked, 32'h0);
		chk(holdover_active, 32'h1);
		complete_run();
	end
endmodule
